// ---- rtl/apm_map.svh ----
`ifndef APM_MAP_SVH
`define APM_MAP_SVH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define APM_OFF_STATUS  8'h00
`define APM_OFF_EVENT   8'h04
`define APM_OFF_COUNT   8'h08
`define APM_OFF_MASK    8'h0c
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define APM_BIT_LOCK      0
`define APM_BIT_RAIL_HIGH 3
`define APM_BIT_RAIL_LOW  2
`define APM_BIT_LIMIT     1
`define APM_BIT_LOSS      0
`define APM_CNT_MAX       4'hf
`define APM_RESET_VAL     8'h00
`endif

// ---- rtl/apm_monitor.sv ----
// Notes on behaviour
// - Status bit 0 shows live lock
// - Rail-high sets sticky event bit 3
// - Rail-low sets sticky event bit 2
// - Count above threshold sets event bit 1
// - Bit 1 uncleared while count exceeds
// - Lock-to-unlock sets sticky event bit 0
// - Counter increments on each lock loss
// - Counter saturates at fifteen, never wraps
// - Counter write loads the written value
// - Reset zeroes all; reserved bits read zero
`timescale 1ns/1ps
`default_nettype none
`include "apm_map.svh"
module apm_monitor (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        pll_lock,
   input  wire logic        pll_rail_high,
   input  wire logic        pll_rail_low,
   input  wire logic [3:0]  lol_threshold,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   output var  logic [1:0]  s_axi_bresp,
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output var  logic        irq
);
   // ----------------------------------------
   // Input synchronisation
   // ----------------------------------------
   apm_pkg::apm_det_t det_raw;
   apm_pkg::apm_det_t det;
   logic              lock_d;
   assign det_raw = '{lock: pll_lock, rail_high: pll_rail_high, rail_low: pll_rail_low};
   // Analog levels are asynchronous to the register clock
   apm_sync #(.WIDTH(3)) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .din     (det_raw),
      .dout    (det)
   );

   // ----------------------------------------
   // Bus slave
   // ----------------------------------------
   logic        aw_held;
   logic [7:0]  aw_addr;
   logic        w_held;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   wire         wr_fire = aw_held && w_held && !s_axi_bvalid;
   wire         rd_fire = s_axi_arvalid && s_axi_arready;
   wire         wr_lane0 = wr_fire && w_strb[0];
   wire         wr_event = wr_lane0 && (aw_addr == `APM_OFF_EVENT);
   wire         wr_count = wr_lane0 && (aw_addr == `APM_OFF_COUNT);
   wire         wr_mask  = wr_lane0 && (aw_addr == `APM_OFF_MASK);
   wire         wr_known = (aw_addr == `APM_OFF_STATUS) || (aw_addr == `APM_OFF_EVENT)
                        || (aw_addr == `APM_OFF_COUNT) || (aw_addr == `APM_OFF_MASK);

   // Write address and data accepted in either order, one at a time
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_addr       <= 8'h00;
         w_data        <= 32'h0000_0000;
         w_strb        <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready  <= !w_held && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
         end
      end
   end

   // Write response, SLVERR for an unmapped address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_known ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ----------------------------------------
   // Lock monitor core
   // ----------------------------------------
   logic [3:0]        lol_count;
   apm_pkg::apm_evt_t events;
   logic [3:0]        mask;
   logic [3:0]        next_count;
   wire               lock_fall = lock_d && !det.lock;
   wire               over_limit = lol_count > lol_threshold;
   wire [3:0]         clr_bits = wr_event ? w_data[3:0] : 4'h0;
   apm_pkg::apm_evt_t set_bits;
   apm_pkg::apm_evt_t next_events;

   // Set terms; limit holds while the condition persists
   assign set_bits = '{rail_high: det.rail_high,
                       rail_low:  det.rail_low,
                       limit:     over_limit,
                       loss:      lock_fall};
   // Set wins over clear; only a write of one clears, a read leaves flags alone
   assign next_events = set_bits | (events & ~clr_bits);
   // Saturating increment, software write loads value
   assign next_count = wr_count ? w_data[3:0]
                     : (lock_fall && lol_count != `APM_CNT_MAX)
                     ? lol_count + 4'h1 : lol_count;

   // Core state, all zero after reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lock_d    <= 1'b0;
         lol_count <= 4'h0;
         events    <= 4'h0;
         mask      <= 4'h0;
      end else begin
         lock_d    <= det.lock;
         lol_count <= next_count;
         events    <= next_events;
         if (wr_mask) begin
            mask <= w_data[3:0];
         end
      end
   end

   // Level interrupt from unmasked events
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(next_events & mask);
      end
   end

   // ----------------------------------------
   // Read channel
   // ----------------------------------------
   logic [31:0] rd_mux;
   // Upper bits always zero
   assign rd_mux = (s_axi_araddr == `APM_OFF_STATUS) ? {31'h0, lock_d}
                 : (s_axi_araddr == `APM_OFF_EVENT)  ? {28'h0, events}
                 : (s_axi_araddr == `APM_OFF_COUNT)  ? {28'h0, lol_count}
                 : (s_axi_araddr == `APM_OFF_MASK)   ? {28'h0, mask}
                 : 32'h0000_0000;
   wire rd_known = (s_axi_araddr == `APM_OFF_STATUS) || (s_axi_araddr == `APM_OFF_EVENT)
                || (s_axi_araddr == `APM_OFF_COUNT) || (s_axi_araddr == `APM_OFF_MASK);

   // One read at a time; arready pulses when arvalid is high and no answer is pending
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= 2'b00;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_known ? 2'b00 : 2'b10;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   AST_LOCK_MIRROR: assert property (@(posedge aclk) disable iff (!aresetn)
      lock_d == $past(det.lock)) else $error("lock status not mirrored");
   AST_RAIL_HIGH: assert property (@(posedge aclk) disable iff (!aresetn)
      det.rail_high |=> events.rail_high) else $error("rail high lost");
   AST_RAIL_LOW: assert property (@(posedge aclk) disable iff (!aresetn)
      det.rail_low |=> events.rail_low) else $error("rail low lost");
   AST_LIMIT_SET: assert property (@(posedge aclk) disable iff (!aresetn)
      over_limit |=> events.limit) else $error("limit flag not set");
   AST_LIMIT_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
      (over_limit && wr_event && w_data[1]) |=> events.limit)
      else $error("limit cleared while over");
   AST_LOSS_SET: assert property (@(posedge aclk) disable iff (!aresetn)
      (lock_d && !det.lock) |=> events.loss) else $error("loss event missed");
   AST_COUNT_INC: assert property (@(posedge aclk) disable iff (!aresetn)
      (lock_fall && !wr_count && lol_count < 4'hf) |=> lol_count == $past(lol_count) + 4'h1)
      else $error("count not incremented");
   AST_COUNT_SAT: assert property (@(posedge aclk) disable iff (!aresetn)
      (lol_count == 4'hf && !wr_count) |=> lol_count == 4'hf)
      else $error("count wrapped");
   AST_COUNT_LOAD: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_count |=> lol_count == $past(w_data[3:0])) else $error("count not loaded");
   AST_RESET_ZERO: assert property (@(posedge aclk)
      !aresetn |=> (lol_count == 4'h0 && events == 4'h0 && !lock_d))
      else $error("state not zero after reset");
   AST_SET_WINS: assert property (@(posedge aclk) disable iff (!aresetn)
      (det.rail_low && wr_event) |=> events.rail_low) else $error("set lost to clear");
   COV_LOSS: cover property (@(posedge aclk) disable iff (!aresetn) lock_fall);
   COV_SAT: cover property (@(posedge aclk) disable iff (!aresetn) lol_count == 4'hf);
   COV_IRQ: cover property (@(posedge aclk) disable iff (!aresetn) irq);
   COV_CLEAR: cover property (@(posedge aclk) disable iff (!aresetn)
      wr_event && events.loss ##1 !events.loss);
endmodule
`default_nettype wire

// ---- rtl/apm_pkg.sv ----
package apm_pkg;
   // Live inputs from the analog lock detector
   typedef struct packed {
      logic lock;
      logic rail_high;
      logic rail_low;
   } apm_det_t;
   // Event flag layout, bit 3 down to bit 0
   typedef struct packed {
      logic rail_high;
      logic rail_low;
      logic limit;
      logic loss;
   } apm_evt_t;
endpackage

// ---- rtl/apm_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser for a bundle of asynchronous levels
module apm_sync #(
   parameter int WIDTH = 3
) (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic [WIDTH-1:0] din,
   output var  logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] stage1;
   // First stage feeds only the second
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stage1 <= '0;
         dout   <= '0;
      end else begin
         stage1 <= din;
         dout   <= stage1;
      end
   end
endmodule
`default_nettype wire

// ---- verification/apm_monitor_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "apm_map.svh"
`define CHK(nm, ex, gt) begin n_checks++; if (32'(gt) !== 32'(ex)) begin n_mismatch++; \
   $display("[FAIL] %s exp %h got %h", nm, 32'(ex), 32'(gt)); end end
module analog_pll_lock_event_monitor_test;
   // ----------------------------------------
   // Stimulus, responses and model state
   // ----------------------------------------
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic        pll_lock = 1'b0;
   logic        pll_rail_high = 1'b0;
   logic        pll_rail_low = 1'b0;
   logic [3:0]  lol_threshold = 4'hf;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h00000000;
   logic [3:0]  wstrb = 4'hf;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [15:0] lfsr_q = 16'd17902;
   int          n_mismatch = 0;
   int          n_checks = 0;
   int          cycles = 0;
   int          evt = 0, cnt = 0, msk = 0, thr = 15;

   always #2.5 aclk = ~aclk;

   apm_monitor apm_monitor_inst (
      .aclk(aclk), .aresetn(aresetn), .pll_lock(pll_lock), .pll_rail_high(pll_rail_high),
      .pll_rail_low(pll_rail_low), .lol_threshold(lol_threshold), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .irq(irq));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // Address and data are offered together and each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
      bit aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (awready) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (wready) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (!bvalid);
      bready <= 1'b0;
      `CHK("bresp", (a > 8'h0c) ? 2 : 0, bresp)
   endtask

   // Reads have no side effect on the event flags
   task automatic rd_chk(input logic [7:0] a, input int ex);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      rready <= 1'b0;
      `CHK("rdata", ex, rdata)
      `CHK("rresp", (a > 8'h0c) ? 2 : 0, rresp)
   endtask

   // Long enough to cover the synchroniser and register stage
   task automatic settle;
      repeat (6) @(posedge aclk);
   endtask

   task automatic irq_chk;
      repeat (3) @(posedge aclk);
      `CHK("irq", (evt & msk) != 0, irq)
   endtask

   task automatic lose;
      pll_lock <= 1'b0;
      settle;
      pll_lock <= 1'b1;
      settle;
      cnt = (cnt < 15) ? cnt + 1 : 15;
      evt |= (cnt > thr) ? 3 : 1;
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Cuts a hang short; the full run needs well under this many cycles
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 8000) begin
         n_mismatch++;
         test_done;
      end
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      logic [31:0] v;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      for (int a = 0; a < 20; a += 4) rd_chk(8'(a), 0);
      pll_lock <= 1'b1;
      settle;
      rd_chk(`APM_OFF_STATUS, 1);
      wr(`APM_OFF_STATUS, 32'hffffffff);
      rd_chk(`APM_OFF_STATUS, 1);
      wr(`APM_OFF_MASK, 32'h0000000f);
      msk = 15;
      wr(`APM_OFF_MASK, 32'h00000000, 4'h0);
      rd_chk(`APM_OFF_MASK, 15);
      // Both rails pulse, then only the high one is cleared by software
      pll_rail_high <= 1'b1;
      pll_rail_low <= 1'b1;
      settle;
      pll_rail_high <= 1'b0;
      pll_rail_low <= 1'b0;
      evt |= 12;
      irq_chk;
      wr(`APM_OFF_EVENT, 32'h00000008);
      evt &= ~8;
      irq_chk;
      rd_chk(`APM_OFF_EVENT, 4);
      irq_chk;
      // Seventeen losses drive the count to its ceiling of fifteen, where it saturates
      lfsr_q = lfsr_next(lfsr_q);
      thr = lfsr_q[2:0];
      lol_threshold <= 4'(thr);
      for (int i = 0; i < 17; i++) begin
         lose;
         rd_chk(`APM_OFF_COUNT, cnt);
      end
      irq_chk;
      rd_chk(`APM_OFF_EVENT, evt);
      wr(`APM_OFF_EVENT, 32'h00000002);
      rd_chk(`APM_OFF_EVENT, evt);
      lol_threshold <= 4'hf;
      thr = 15;
      lfsr_q = lfsr_next(lfsr_q);
      v = {lfsr_q, lfsr_q};
      wr(`APM_OFF_COUNT, v);
      cnt = v[3:0];
      rd_chk(`APM_OFF_COUNT, cnt);
      wr(`APM_OFF_COUNT, 32'hfffffff0);
      cnt = 0;
      rd_chk(`APM_OFF_COUNT, 0);
      // With everything masked an event must not reach the interrupt
      wr(`APM_OFF_MASK, 32'h00000000);
      msk = 0;
      lose;
      irq_chk;
      rd_chk(`APM_OFF_EVENT, evt);
      test_done;
   end
endmodule
`default_nettype wire
